//--- rtl/timer_counter_prescaler.sv
// Purpose: 8-bit timer/counter with a prescaler shared with the watchdog.
// Assumes: clk_sys is the oscillator clock; the CPU writes at phase_four.
// Notes:   Prescaler is synchronous here, so it tracks the ripple divider
//          only to within one oscillator period.

module timer_counter_prescaler (
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic [4:0] data_addr,
  input  wire logic       data_wr,
  input  wire logic [7:0] data_wdata,
  output logic      [7:0] data_rdata,
  input  wire logic       cfg_load,
  input  wire logic       dir_load,
  input  wire logic [7:0] work_data,
  input  wire logic       watchdog_clear_op,
  input  wire logic       watchdog_tick,
  output logic            watchdog_timeout,
  input  wire logic       port_bit_two_in,
  output logic      [5:0] pin_oe_n,
  output logic            wake_disable,
  output logic            pullup_disable
);

  logic       phase_two;
  logic       phase_four;
  logic       ext_level;
  logic       wdt_level;

  logic [7:0] timer_count_r;
  logic [7:0] timer_config_r;
  logic [5:0] pin_direction_r;
  logic [7:0] ps_cnt_r;
  logic [1:0] inhibit_r;
  logic       ext_prev_r;
  logic       wdt_prev_r;
  logic       tap_prev_r;
  logic       sample_r;
  logic       sample_prev_r;
  logic [7:0] rdata_r;
  logic       timeout_r;
  logic [5:0] oe_n_r;

  logic       clock_source_select;
  logic       source_edge_select;
  logic       prescaler_assign;
  logic [2:0] prescale_ratio_field;
  logic       ext_active;
  logic       ext_rise;
  logic       wdt_pulse;
  logic       ps_src;
  logic       ps_clear;
  logic       ps_tap;
  logic       tap_rise;
  logic       sync_level;
  logic       ext_inc;
  logic       inc_req;
  logic       timer_wr;

  phase_gen u_phase_gen (
    .clk_sys    (clk_sys),
    .reset      (reset),
    .phase_two  (phase_two),
    .phase_four (phase_four)
  );

  pin_sync u_ext_sync (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .async_in  (port_bit_two_in),
    .level_out (ext_level)
  );

  // Watchdog oscillator runs on its own; its tick is a foreign level
  pin_sync u_wdt_sync (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .async_in  (watchdog_tick),
    .level_out (wdt_level)
  );

  assign clock_source_select  = timer_config_r[timer_pkg::CFG_SOURCE_BIT];
  assign source_edge_select   = timer_config_r[timer_pkg::CFG_EDGE_BIT];
  assign prescaler_assign     = timer_config_r[timer_pkg::CFG_ASSIGN_BIT];
  assign prescale_ratio_field =
    timer_config_r[timer_pkg::CFG_RATIO_HI:timer_pkg::CFG_RATIO_LO];
  assign timer_wr = data_wr && (data_addr == timer_pkg::TIMER_COUNT_ADDR);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      timer_config_r <= timer_pkg::CONFIG_RESET;
    end else if (cfg_load) begin
      timer_config_r <= work_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pin_direction_r <= timer_pkg::DIR_RESET;
    end else if (dir_load) begin
      pin_direction_r <= work_data[5:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      oe_n_r <= timer_pkg::DIR_RESET;
    end else begin
      oe_n_r <= pin_direction_r;
      oe_n_r[timer_pkg::PORT_BIT_TWO] <=
        pin_direction_r[timer_pkg::PORT_BIT_TWO] | clock_source_select;
    end
  end

  assign ext_active = ext_level ^ source_edge_select;
  assign ext_rise   = ext_active & ~ext_prev_r;
  assign wdt_pulse  = wdt_level & ~wdt_prev_r;

  // Idle pin with falling edge selected reads high; seeding avoids a
  // false edge right after reset
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ext_prev_r <= ext_active;
      wdt_prev_r <= 1'b0;
    end else begin
      ext_prev_r <= ext_active;
      wdt_prev_r <= wdt_level;
    end
  end

  always_comb begin
    if (prescaler_assign) begin
      ps_src = wdt_pulse;
    end else if (clock_source_select) begin
      ps_src = ext_rise;
    end else begin
      ps_src = phase_four;
    end
  end

  assign ps_clear = (timer_wr && !prescaler_assign) ||
                    (watchdog_clear_op && prescaler_assign);

  // no software load or read path
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ps_cnt_r <= 8'h00;
    end else if (ps_clear) begin
      ps_cnt_r <= 8'h00;
    end else if (ps_src) begin
      ps_cnt_r <= ps_cnt_r + 8'h01;
    end
  end

  assign ps_tap   = timer_pkg::prescale_tap(ps_cnt_r, prescale_ratio_field);
  assign tap_rise = ps_tap & ~tap_prev_r;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      tap_prev_r <= 1'b0;
    end else begin
      tap_prev_r <= ps_tap;
    end
  end

  assign sync_level = prescaler_assign ? ext_active : ps_tap;

  // sampling at phases two and four
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sample_r <= sync_level;
    end else if (phase_two || phase_four) begin
      sample_r <= sync_level;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sample_prev_r <= sync_level;
    end else begin
      sample_prev_r <= sample_r;
    end
  end

  assign ext_inc = sample_r & ~sample_prev_r;

  always_comb begin
    if (clock_source_select) begin
      inc_req = ext_inc;
    end else if (prescaler_assign) begin
      inc_req = phase_four;
    end else begin
      inc_req = tap_rise;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      inhibit_r <= 2'h0;
    end else if (timer_wr) begin
      inhibit_r <= timer_pkg::WRITE_INHIBIT;
    end else if (phase_four && inhibit_r != 2'h0) begin
      inhibit_r <= inhibit_r - 2'h1;
    end
  end

  // count kept across resets
  // Left out of reset on purpose so a wake-up does not lose the count
  always_ff @(posedge clk_sys) begin
    if (timer_wr) begin
      timer_count_r <= data_wdata;
    end else if (inc_req && inhibit_r == 2'h0) begin
      timer_count_r <= timer_count_r + 8'h01;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rdata_r <= 8'h00;
    end else if (data_addr == timer_pkg::TIMER_COUNT_ADDR) begin
      rdata_r <= timer_count_r;
    end else begin
      rdata_r <= 8'h00;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      timeout_r <= 1'b0;
    end else if (prescaler_assign) begin
      timeout_r <= tap_rise;
    end else begin
      timeout_r <= wdt_pulse;
    end
  end

  assign data_rdata       = rdata_r;
  assign watchdog_timeout = timeout_r;
  assign pin_oe_n         = oe_n_r;
  assign wake_disable     = timer_config_r[timer_pkg::CFG_WAKE_BIT];
  assign pullup_disable   = timer_config_r[timer_pkg::CFG_PULLUP_BIT];

endmodule : timer_counter_prescaler

//--- include/timer_pkg.sv
// Purpose: Shared constants for the timer/counter with prescaler.
// Assumes: clk_sys is the oscillator clock; one period is one phase.
// Notes:   Offsets, field positions, reset values and phase counts.
package timer_pkg;

  localparam int          ADDR_W             = 5;
  localparam int          DATA_W             = 8;
  localparam int          DIR_W              = 6;
  localparam int          PS_W               = 8;
  localparam logic [4:0]  TIMER_COUNT_ADDR   = 5'h01;

  // Timer configuration field positions
  localparam int          CFG_WAKE_BIT       = 7;
  localparam int          CFG_PULLUP_BIT     = 6;
  localparam int          CFG_SOURCE_BIT     = 5;
  localparam int          CFG_EDGE_BIT       = 4;
  localparam int          CFG_ASSIGN_BIT     = 3;
  localparam int          CFG_RATIO_HI       = 2;
  localparam int          CFG_RATIO_LO       = 0;

  localparam logic [7:0]  CONFIG_RESET       = 8'hFF;
  localparam logic [5:0]  DIR_RESET          = 6'h3F;
  localparam int          PORT_BIT_TWO       = 2;

  // Instruction cycle made of four phases
  localparam logic [1:0]  PHASE_ONE_IDX      = 2'h0;
  localparam logic [1:0]  PHASE_TWO_IDX      = 2'h1;
  localparam logic [1:0]  PHASE_FOUR_IDX     = 2'h3;

  localparam int          CLK_PERIOD_NS      = 5;
  localparam int          TOSC_NS            = 5;
  localparam int          TOSC_CYCLES        = (TOSC_NS + CLK_PERIOD_NS - 1)
                                               / CLK_PERIOD_NS;
  localparam logic [1:0]  WRITE_INHIBIT      = 2'h2;

  // Tap of the prescaler count for ratio 2^(ratio+1)
  function automatic logic prescale_tap(input logic [7:0] cnt,
                                        input logic [2:0] ratio);
    prescale_tap = cnt[ratio];
  endfunction : prescale_tap

endpackage : timer_pkg

//--- rtl/phase_gen.sv
// Purpose: Divides the oscillator clock into four instruction phases.
// Assumes: Synchronous active-high reset restarts at the first phase.
// Notes:   Strobes are one clock wide and decoded from the phase count.
module phase_gen (
  input  wire logic clk_sys,
  input  wire logic reset,
  output logic      phase_two,
  output logic      phase_four
);

  logic [1:0] phase_r;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      phase_r <= timer_pkg::PHASE_ONE_IDX;
    end else begin
      phase_r <= phase_r + 2'h1;
    end
  end

  assign phase_two  = (phase_r == timer_pkg::PHASE_TWO_IDX);
  assign phase_four = (phase_r == timer_pkg::PHASE_FOUR_IDX);

endmodule : phase_gen

//--- rtl/pin_sync.sv
// Purpose: Brings an asynchronous level into the clk_sys domain.
// Assumes: Input may change at any time relative to clk_sys.
// Notes:   A change is taken once the second and third stages agree.
module pin_sync (
  input  wire logic clk_sys,
  input  wire logic reset,
  input  wire logic async_in,
  output logic      level_out
);

  logic stage1_r;
  logic stage2_r;
  logic stage3_r;
  logic level_r;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      stage1_r <= 1'b0;
      stage2_r <= 1'b0;
      stage3_r <= 1'b0;
    end else begin
      stage1_r <= async_in;
      stage2_r <= stage1_r;
      stage3_r <= stage2_r;
    end
  end

  // Holding on disagreement filters a single metastable resolution
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      level_r <= 1'b0;
    end else if (stage2_r == stage3_r) begin
      level_r <= stage3_r;
    end
  end

  assign level_out = level_r;

endmodule : pin_sync

//--- verif/timer_counter_prescaler_asserts.sv
// Purpose: Port-level checks for the timer/counter block.
// Assumes: Config is tracked from cfg_load pulses.
// Notes:   Read-back and step checks need the address held on the counter; the unmapped check needs it elsewhere.
module timer_checker (
  input wire logic       clk_sys,
  input wire logic       reset,
  input wire logic [4:0] data_addr,
  input wire logic       data_wr,
  input wire logic [7:0] data_wdata,
  input wire logic [7:0] data_rdata,
  input wire logic       cfg_load,
  input wire logic       dir_load,
  input wire logic [7:0] work_data,
  input wire logic       watchdog_clear_op,
  input wire logic       watchdog_tick,
  input wire logic       watchdog_timeout,
  input wire logic       port_bit_two_in,
  input wire logic [5:0] pin_oe_n,
  input wire logic       wake_disable,
  input wire logic       pullup_disable
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  logic [7:0] cfg_r;
  logic [2:0] hist_r;
  logic       steady;
  always_ff @(posedge clk_sys) begin
    cfg_r  <= reset ? 8'hFF : (cfg_load ? work_data : cfg_r);
    hist_r <= {hist_r[1:0], data_addr == 5'h01 && !data_wr && !reset};
  end
  // Read path settled, so no write or reset can explain a jump
  assign steady = hist_r == 3'h7 && data_addr == 5'h01 && !data_wr;

  a_reset_values: assert property ($fell(reset) |->
    pin_oe_n == 6'h3F && wake_disable && pullup_disable)
    else $error("reset values wrong");
  a_pin_forced: assert property (cfg_r[5] && $past(cfg_r[5]) |->
    pin_oe_n[2]) else $error("port bit two not forced to input");
  a_dir_follow: assert property (dir_load ##1 !dir_load |=>
    pin_oe_n[1:0] == $past(work_data[1:0], 2) &&
    pin_oe_n[5:3] == $past(work_data[5:3], 2))
    else $error("direction bits not loaded");
  a_read_other: assert property (data_addr != 5'h01 |=>
    data_rdata == 8'h00) else $error("unmapped read not zero");
  a_read_back: assert property (data_wr && data_addr == 5'h01 ##1
    data_addr == 5'h01 && !data_wr |=> data_rdata == $past(data_wdata, 2))
    else $error("written count not read back");
  a_step_one: assert property (steady |->
    data_rdata == $past(data_rdata) ||
    data_rdata == $past(data_rdata) + 8'h01)
    else $error("count jumped");
  a_timer_gap: assert property (steady && !cfg_r[5] && cfg_r[3] &&
    $changed(data_rdata) |=> $stable(data_rdata) [*3])
    else $error("timer stepped faster than once per cycle");
  a_timeout_pulse: assert property (watchdog_timeout |=>
    !watchdog_timeout) else $error("timeout pulse too long");

  c_counter_mode: cover property (cfg_load && work_data[5]);
  c_timeout: cover property (watchdog_timeout);
  c_count_write: cover property (data_wr && data_addr == 5'h01);
endmodule : timer_checker

bind timer_counter_prescaler timer_checker timer_checker_inst (
  .clk_sys(clk_sys), .reset(reset), .data_addr(data_addr),
  .data_wr(data_wr), .data_wdata(data_wdata), .data_rdata(data_rdata),
  .cfg_load(cfg_load), .dir_load(dir_load), .work_data(work_data),
  .watchdog_clear_op(watchdog_clear_op), .watchdog_tick(watchdog_tick),
  .watchdog_timeout(watchdog_timeout), .port_bit_two_in(port_bit_two_in),
  .pin_oe_n(pin_oe_n), .wake_disable(wake_disable),
  .pullup_disable(pullup_disable));

//--- verif/count_clock_source.sv
// Purpose: External count clock driving the shared port pin.
// Assumes: Pin has no pull; the source parks it low between bursts.
// Notes:   Half periods off the 2.5 ns grid keep edges unaligned.
module count_clock_source (
  output logic pin_level
);
  timeunit 1ns;
  timeprecision 100ps;
  initial pin_level = 1'b0;
  // levels held well past the minimum
  task automatic send(input int n, input real half_ns);
    repeat (n) begin
      pin_level = 1'b1;
      #(half_ns);
      pin_level = 1'b0;
      #(half_ns);
    end
  endtask : send
endmodule : count_clock_source

//--- verif/tb_top.sv
// Purpose: Self-checking bench for the timer/counter block.
// Assumes: Phase four is every fourth edge after reset release.
// Notes:   Expected values come from a small integer model.
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk_sys, reset, data_wr, cfg_load, dir_load;
  logic       watchdog_clear_op, watchdog_tick, watchdog_timeout;
  logic       port_bit_two_in, wake_disable, pullup_disable;
  logic [4:0] data_addr;
  logic [7:0] data_wdata, data_rdata, work_data;
  logic [5:0] pin_oe_n;
  int         fails, comparisons, cyc, tocnt, k, n, seed;

  timer_counter_prescaler timer_counter_prescaler_inst (
    .clk_sys(clk_sys), .reset(reset), .data_addr(data_addr),
    .data_wr(data_wr), .data_wdata(data_wdata), .data_rdata(data_rdata),
    .cfg_load(cfg_load), .dir_load(dir_load), .work_data(work_data),
    .watchdog_clear_op(watchdog_clear_op), .watchdog_tick(watchdog_tick),
    .watchdog_timeout(watchdog_timeout), .port_bit_two_in(port_bit_two_in),
    .pin_oe_n(pin_oe_n), .wake_disable(wake_disable),
    .pullup_disable(pullup_disable));
  count_clock_source count_clock_source_inst (.pin_level(port_bit_two_in));

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= reset ? 0 : cyc + 1;
    tocnt <= tocnt + (watchdog_timeout === 1'b1);
  end

  task automatic tick(input int c = 1);
    repeat (c) @(posedge clk_sys);
  endtask : tick
  task automatic give_verdict();
    if (fails == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : give_verdict
  task automatic check(input string what, input int e,
                       input logic [15:0] got);
    comparisons++;
    if (got !== e[15:0]) begin
      fails++;
      $display("ERROR %s expected %0h seen %0h", what, e, got);
    end
  endtask : check
  // Writes must land on a phase four edge, or the inhibit slips
  task automatic wr_cnt(input logic [7:0] v);
    while (cyc % 4 != 2) tick();
    data_addr <= 5'h01;
    data_wr <= 1'b1;
    data_wdata <= v;
    tick();
    data_wr <= 1'b0;
  endtask : wr_cnt
  task automatic load(input logic c, input logic [7:0] v);
    cfg_load <= c;
    dir_load <= !c;
    work_data <= v;
    tick();
    cfg_load <= 1'b0;
    dir_load <= 1'b0;
    tick(2);
  endtask : load
  task automatic wait_step(output int c);
    logic [7:0] was;
    was = data_rdata;
    c = 0;
    while (data_rdata === was) begin
      tick();
      c++;
      if (c > 3000) begin
        fails++;
        give_verdict();
      end
    end
  endtask : wait_step

  initial begin
    seed = 32'h3619340E;
    {reset, data_wr, cfg_load, dir_load, watchdog_clear_op} = 5'h1F;
    {data_wr, cfg_load, dir_load, watchdog_clear_op, watchdog_tick} = 5'h00;
    data_addr = 5'h02;
    data_wdata = 8'h00;
    work_data = 8'h00;
    tick(12);
    reset <= 1'b0;
    load(1'b0, 8'h00);
    check("rdata_unmapped", 0, data_rdata);
    load(1'b1, 8'h08);
    check("oe_timer", 0, pin_oe_n);
    n = $random(seed);
    wr_cnt(n[7:0]);
    tick(3);
    check("count_write", n & 255, data_rdata);
    wait_step(k);
    check("inhibit_gap", 11, k);
    check("count_step", (n + 1) & 255, data_rdata);
    wait_step(k);
    check("cycle_gap", 4, k);
    for (int r = 0; r < 8; r++) begin
      load(1'b1, 8'(r));
      wait_step(k);
      wait_step(k);
      check("ratio_gap", 8 << r, k);
    end
    for (int m = 0; m < 4; m++) begin
      load(1'b1, {2'b00, 1'b1, m[0], !m[1], 3'b000});
      tick(12);
      wr_cnt(8'h00);
      tick(12);
      n = 2 * (3 + $unsigned($random(seed)) % 3);
      count_clock_source_inst.send(n, 20.7 + m);
      tick(12);
      check("edges", m[1] ? n / 2 : n, data_rdata);
      check("oe_forced", 8'h04, pin_oe_n);
    end
    for (int a = 0; a < 2; a++) begin
      // clear watchdog and count before switching
      watchdog_clear_op <= 1'b1;
      tick();
      watchdog_clear_op <= 1'b0;
      wr_cnt(8'h00);
      tick(2);
      load(1'b1, a ? 8'h08 : 8'h00);
      watchdog_clear_op <= 1'b1;
      tick();
      watchdog_clear_op <= 1'b0;
      tick(4);
      k = tocnt;
      repeat (4) begin
        watchdog_tick <= 1'b1;
        tick(6);
        watchdog_tick <= 1'b0;
        tick(6);
      end
      tick(8);
      check("timeouts", a ? 2 : 4, tocnt - k);
    end
    load(1'b1, 8'h28);
    wr_cnt(8'hA5);
    tick(4);
    reset <= 1'b1;
    tick(12);
    reset <= 1'b0;
    tick(3);
    check("count_kept", 8'hA5, data_rdata);
    check("oe_reset", 8'h3F, pin_oe_n);
    check("cfg_flags", 3, {wake_disable, pullup_disable});
    give_verdict();
  end
endmodule : tb_top
